/* design/pwmtb_pkg.sv */
// constants, register map and types of the pwm time base channel
package pwmtb_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int PRE_W  = 12;
  localparam int DB_W   = 10;

  localparam logic [ADDR_W-1:0] OFS_CTL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_FINE   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PHASE  = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h0a;
  localparam logic [ADDR_W-1:0] OFS_CMP_A  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CMP_CT = 8'h12;
  localparam logic [ADDR_W-1:0] OFS_ACT_A  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DB_CTL = 8'h16;
  localparam logic [ADDR_W-1:0] OFS_RED    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_FED    = 8'h1a;

  // count mode 3h (frozen) and fast prescale 1 out of reset
  localparam logic [DATA_W-1:0] CTL_RESET = 16'h0083;

  localparam int STS_DIR  = 0;
  localparam int STS_SYNC = 1;
  localparam int STS_MAX  = 2;

  localparam logic [1:0] SYNC_PASS    = 2'h0;
  localparam logic [1:0] SYNC_ZERO    = 2'h1;
  localparam logic [1:0] POL_HI_COMPL = 2'h2;

  typedef enum logic [1:0] {CNT_UP, CNT_DOWN, CNT_UPDOWN, CNT_FREEZE} pwmtb_mode_e;
  typedef enum logic [1:0] {ACT_NONE, ACT_CLEAR, ACT_SET, ACT_TOGGLE} pwmtb_act_e;
  typedef enum logic [1:0] {LOAD_ZERO, LOAD_PERIOD, LOAD_EITHER, LOAD_FROZEN} pwmtb_load_e;

  typedef struct packed {
    logic [1:0]  emulation;
    logic        phase_direction;
    logic [2:0]  clock_prescale;
    logic [2:0]  fast_clock_prescale;
    logic        software_forced_sync;
    logic [1:0]  sync_out_source;
    logic        period_load_select;
    logic        phase_load_enable;
    pwmtb_mode_e count_mode;
  } pwmtb_ctl_s;

  typedef struct packed {
    pwmtb_load_e compare_a_load_event;
    logic        reserved;
    logic        compare_a_shadow_select;
  } pwmtb_cmp_ctl_s;

  typedef struct packed {
    pwmtb_act_e compare_a_down_action;
    pwmtb_act_e compare_a_up_action;
    pwmtb_act_e period_event_action;
    pwmtb_act_e zero_event_action;
  } pwmtb_act_s;

  typedef struct packed {
    logic [1:0] dead_band_polarity;
    logic       fall_en;
    logic       rise_en;
  } pwmtb_db_ctl_s;

  typedef struct packed {
    pwmtb_db_ctl_s   ctl;
    logic [DB_W-1:0] red;
    logic [DB_W-1:0] fed;
  } pwmtb_db_cfg_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } pwmtb_bus_s;

endpackage

/* design/pwmtb_dead_band.sv */
// dead band delay for the complementary output pair
`timescale 1ns/10ps
module pwmtb_dead_band (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_tick,
  input  wire logic                i_raw,
  input  pwmtb_pkg::pwmtb_db_cfg_s i_cfg,
  output logic                     o_a,
  output logic                     o_b
);
  import pwmtb_pkg::*;

  typedef struct packed {
    logic [DB_W-1:0] rcnt;
    logic [DB_W-1:0] fcnt;
    logic            q;
    logic            rd;
    logic            fd;
    logic            a;
    logic            b;
  } pwmtb_db_state_s;

  pwmtb_db_state_s s;
  pwmtb_db_state_s nx;
  logic            b_src;

  always_comb
  begin
    nx   = s;
    nx.q = i_raw;
    // rising edge waits red ticks, falling edge passes at once
    if (!i_raw)
    begin
      nx.rd   = 1'b0;
      nx.rcnt = '0;
    end
    else if (!s.rd)
    begin
      if (s.rcnt >= i_cfg.red)
        nx.rd = 1'b1;
      else if (i_tick)
        nx.rcnt = s.rcnt + 1'b1;
    end
    if (i_raw)
    begin
      nx.fd   = 1'b1;
      nx.fcnt = '0;
    end
    else if (s.fd)
    begin
      if (s.fcnt >= i_cfg.fed)
        nx.fd = 1'b0;
      else if (i_tick)
        nx.fcnt = s.fcnt + 1'b1;
    end
    b_src = i_cfg.ctl.fall_en ? s.fd : s.q;
    nx.a  = i_cfg.ctl.rise_en ? s.rd : s.q;
    nx.b  = (i_cfg.ctl.dead_band_polarity == POL_HI_COMPL) ? !b_src : b_src;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      s <= '0;
    else
      s <= nx;
  end

  assign o_a = s.a;
  assign o_b = s.b;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_full_compl;
    i_cfg.ctl.rise_en && i_cfg.ctl.fall_en && i_cfg.ctl.dead_band_polarity == POL_HI_COMPL;
  endsequence

  a_rise_delay: assert property (s_full_compl ##0 ($rose(i_raw) && i_cfg.red != '0) |=> !o_a [*2])
    else $error("output a rose without its delay");
  a_fall_delay: assert property (s_full_compl ##0 ($fell(i_raw) && i_cfg.fed != '0) |=> !o_b [*2])
    else $error("output b rose without its delay");
  a_no_overlap: assert property (s_full_compl ##0 $stable(i_cfg) |-> !(o_a && o_b))
    else $error("both outputs high together");

endmodule

/* design/pwmtb_channel.sv */
// pwm channel: time base, sync and phase load, compare a, output a actions
//
// Overview of operation
// - up count runs zero to period inclusive
// - output a sets at zero, clears compare-up
// - period 1200, compare 600 gives half duty
// - slave phase offset register sets the shift
// - new phase offset accepted every cycle
// - phase load disabled ignores phase offset
// - fine phase exists only with extension
// - control resets to mode 3h, fast 1
// - sync pulse loads phase when enabled
// - up-down direction after sync from bit 13
// - time base clock is system over prescalers
`timescale 1ns/10ps
module pwmtb_channel #(
  parameter bit HAS_FINE_PHASE = 1'b1
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  input  pwmtb_pkg::pwmtb_bus_s        i_bus,
  input  wire logic                    i_sync_in,
  output logic [pwmtb_pkg::DATA_W-1:0] o_rdata,
  output logic                         o_sync_out,
  output logic                         o_out_a,
  output logic                         o_out_b
);
  import pwmtb_pkg::*;

  typedef struct packed {
    pwmtb_ctl_s        ctl;
    logic              dir;
    logic              sync_flag;
    logic              max_flag;
    logic [DATA_W-1:0] fine;
    logic [DATA_W-1:0] phase;
    logic [DATA_W-1:0] count;
    logic [DATA_W-1:0] period;
    logic [DATA_W-1:0] period_sh;
    logic [DATA_W-1:0] cmp_a;
    logic [DATA_W-1:0] cmp_a_sh;
    pwmtb_cmp_ctl_s    cmp_ctl;
    pwmtb_act_s        act;
    pwmtb_db_cfg_s     db;
    logic              raw_a;
    logic [PRE_W-1:0]  pre;
    logic              tick;
    logic              sync_pend;
    logic              sync_out;
    logic [2:0]        sy;
    logic              sy_lvl;
    logic [DATA_W-1:0] rdata;
  } pwmtb_state_s;

  localparam int ST_W = $bits(pwmtb_state_s);
  localparam pwmtb_state_s ST_RST = pwmtb_state_s'({CTL_RESET, {(ST_W-DATA_W){1'b0}}});

  pwmtb_state_s      s;
  pwmtb_state_s      nx;
  logic [1:0]        rst_pipe;
  logic              rst_n;
  pwmtb_ctl_s        wctl;
  logic [3:0]        fast_f;
  logic [7:0]        slow_f;
  logic [PRE_W-1:0]  div;
  logic              run;
  logic              zero_ev;
  logic              prd_ev;
  logic              cmp_ev;
  logic              up_now;
  logic              load_phase;
  logic              sync_pulse;
  logic              sw_sync;
  logic              wr_ctl;
  logic              wr_sts;
  logic              wr_count;
  logic [DATA_W-1:0] rd_mux;

  function automatic logic hit_wr(input pwmtb_bus_s b, input logic [ADDR_W-1:0] ofs);
    hit_wr = b.wr && (b.addr == ofs);
  endfunction

  function automatic logic act_apply(input pwmtb_act_e act, input logic cur);
    case (act)
      ACT_CLEAR:  act_apply = 1'b0;
      ACT_SET:    act_apply = 1'b1;
      ACT_TOGGLE: act_apply = !cur;
      default:    act_apply = cur;
    endcase
  endfunction

  // reset is released on the clock so no flop leaves reset a cycle apart
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];

  assign wctl     = pwmtb_ctl_s'(i_bus.wdata);
  assign wr_ctl   = hit_wr(i_bus, OFS_CTL);
  assign wr_sts   = hit_wr(i_bus, OFS_STATUS);
  assign wr_count = hit_wr(i_bus, OFS_COUNT);
  assign sw_sync  = wr_ctl && wctl.software_forced_sync;

  // pin sync counts once the second and third stages agree
  assign sync_pulse = (s.sy[2] == s.sy[1]) && s.sy[1] && !s.sy_lvl;

  assign fast_f = (s.ctl.fast_clock_prescale == 3'h0) ? 4'h1
                : {s.ctl.fast_clock_prescale, 1'b0};
  assign slow_f = 8'h01 << s.ctl.clock_prescale;
  assign div    = fast_f * slow_f;

  assign run        = s.tick && (s.ctl.count_mode != CNT_FREEZE);
  assign zero_ev    = (s.count == '0);
  assign prd_ev     = (s.count == s.period);
  assign cmp_ev     = (s.count == s.cmp_a);
  assign up_now     = (s.ctl.count_mode == CNT_UP)
                   || ((s.ctl.count_mode == CNT_UPDOWN) && s.dir);
  assign load_phase = s.sync_pend && s.ctl.phase_load_enable;

  always_comb
  begin
    nx                          = s;
    nx.rdata                    = '0;
    nx.sync_out                 = 1'b0;
    nx.ctl.software_forced_sync = 1'b0;
    nx.sy                       = {s.sy[1:0], i_sync_in};
    if (s.sy[2] == s.sy[1])
      nx.sy_lvl = s.sy[1];

    // time base clock divider
    nx.tick = (s.pre >= div - 12'h1);
    nx.pre  = nx.tick ? '0 : s.pre + 12'h1;

    // a sync waits for the next time base tick outside freeze mode and is consumed there
    nx.sync_pend = (s.sync_pend && !run) || sync_pulse || sw_sync;
    if (sw_sync || (sync_pulse && s.ctl.sync_out_source == SYNC_PASS))
      nx.sync_out = 1'b1;

    if (run)
    begin
      if (zero_ev)
        nx.raw_a = act_apply(s.act.zero_event_action, nx.raw_a);
      if (prd_ev)
        nx.raw_a = act_apply(s.act.period_event_action, nx.raw_a);
      if (cmp_ev && up_now)
        nx.raw_a = act_apply(s.act.compare_a_up_action, nx.raw_a);
      if (cmp_ev && !up_now)
        nx.raw_a = act_apply(s.act.compare_a_down_action, nx.raw_a);
      if (zero_ev && s.ctl.sync_out_source == SYNC_ZERO)
        nx.sync_out = 1'b1;

      if (load_phase)
      begin
        nx.count = s.phase;
        if (s.ctl.count_mode == CNT_UPDOWN)
          nx.dir = s.ctl.phase_direction;
      end
      else
      begin
        case (s.ctl.count_mode)
          CNT_UP:
          begin
            nx.dir   = 1'b1;
            nx.count = prd_ev ? '0 : s.count + 16'h1;
          end
          CNT_DOWN:
          begin
            nx.dir   = 1'b0;
            nx.count = zero_ev ? s.period : s.count - 16'h1;
          end
          default:
          begin
            if (s.dir)
            begin
              if (prd_ev)
              begin
                nx.dir   = 1'b0;
                nx.count = s.count - 16'h1;
              end
              else
                nx.count = s.count + 16'h1;
            end
            else if (zero_ev)
            begin
              nx.dir   = 1'b1;
              nx.count = s.count + 16'h1;
            end
            else
              nx.count = s.count - 16'h1;
          end
        endcase
      end

      // shadow transfers happen on the same tick as the event
      if (!s.ctl.period_load_select && zero_ev)
        nx.period = s.period_sh;
      if (!s.cmp_ctl.compare_a_shadow_select)
      begin
        case (s.cmp_ctl.compare_a_load_event)
          LOAD_ZERO:   if (zero_ev) nx.cmp_a = s.cmp_a_sh;
          LOAD_PERIOD: if (prd_ev) nx.cmp_a = s.cmp_a_sh;
          LOAD_EITHER: if (zero_ev || prd_ev) nx.cmp_a = s.cmp_a_sh;
          default:     nx.cmp_a = s.cmp_a;
        endcase
      end
    end

    // software writes win over the counter in the same cycle
    if (i_bus.wr)
    begin
      if (i_bus.addr == OFS_CTL)
      begin
        nx.ctl                      = wctl;
        nx.ctl.software_forced_sync = 1'b0;
      end
      else if (i_bus.addr == OFS_FINE)
      begin
        if (HAS_FINE_PHASE)
          nx.fine = i_bus.wdata;
      end
      else if (i_bus.addr == OFS_PHASE)
        nx.phase = i_bus.wdata;
      else if (i_bus.addr == OFS_COUNT)
        nx.count = i_bus.wdata;
      else if (i_bus.addr == OFS_PERIOD)
      begin
        nx.period_sh = i_bus.wdata;
        if (s.ctl.period_load_select)
          nx.period = i_bus.wdata;
      end
      else if (i_bus.addr == OFS_CMP_A)
      begin
        nx.cmp_a_sh = i_bus.wdata;
        if (s.cmp_ctl.compare_a_shadow_select)
          nx.cmp_a = i_bus.wdata;
      end
      else if (i_bus.addr == OFS_CMP_CT)
        nx.cmp_ctl = pwmtb_cmp_ctl_s'(i_bus.wdata[$bits(pwmtb_cmp_ctl_s)-1:0]);
      else if (i_bus.addr == OFS_ACT_A)
        nx.act = pwmtb_act_s'(i_bus.wdata[$bits(pwmtb_act_s)-1:0]);
      else if (i_bus.addr == OFS_DB_CTL)
        nx.db.ctl = pwmtb_db_ctl_s'(i_bus.wdata[$bits(pwmtb_db_ctl_s)-1:0]);
      else if (i_bus.addr == OFS_RED)
        nx.db.red = i_bus.wdata[DB_W-1:0];
      else if (i_bus.addr == OFS_FED)
        nx.db.fed = i_bus.wdata[DB_W-1:0];
    end

    // write one to clear, a new event in the same cycle keeps the flag
    nx.sync_flag = (s.sync_flag && !(wr_sts && i_bus.wdata[STS_SYNC])) || sync_pulse;
    nx.max_flag  = (s.max_flag && !(wr_sts && i_bus.wdata[STS_MAX])) || (s.count == '1);

    if (i_bus.rd)
      nx.rdata = rd_mux;
  end

  // unmapped and absent offsets read zero and ignore writes
  always_comb
  begin
    rd_mux = '0;
    if (i_bus.addr == OFS_CTL)
      rd_mux = s.ctl;
    else if (i_bus.addr == OFS_STATUS)
    begin
      rd_mux[STS_DIR]  = s.dir;
      rd_mux[STS_SYNC] = s.sync_flag;
      rd_mux[STS_MAX]  = s.max_flag;
    end
    else if (i_bus.addr == OFS_FINE)
      rd_mux = HAS_FINE_PHASE ? s.fine : '0;
    else if (i_bus.addr == OFS_PHASE)
      rd_mux = s.phase;
    else if (i_bus.addr == OFS_COUNT)
      rd_mux = s.count;
    else if (i_bus.addr == OFS_PERIOD)
      rd_mux = s.period;
    else if (i_bus.addr == OFS_CMP_A)
      rd_mux = s.cmp_a;
    else if (i_bus.addr == OFS_CMP_CT)
      rd_mux = DATA_W'(s.cmp_ctl);
    else if (i_bus.addr == OFS_ACT_A)
      rd_mux = DATA_W'(s.act);
    else if (i_bus.addr == OFS_DB_CTL)
      rd_mux = DATA_W'(s.db.ctl);
    else if (i_bus.addr == OFS_RED)
      rd_mux = DATA_W'(s.db.red);
    else if (i_bus.addr == OFS_FED)
      rd_mux = DATA_W'(s.db.fed);
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= ST_RST;
    else
      s <= nx;
  end

  pwmtb_dead_band u_dead_band (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_tick  (s.tick),
    .i_raw   (s.raw_a),
    .i_cfg   (s.db),
    .o_a     (o_out_a),
    .o_b     (o_out_b)
  );

  assign o_rdata    = s.rdata;
  assign o_sync_out = s.sync_out;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  sequence s_sync_taken;
    run && load_phase && !wr_count;
  endsequence

  sequence s_plain_step;
    run && !load_phase && !wr_count;
  endsequence

  a_ctl_reset: assert property (!$past(rst_n) |-> s.ctl == pwmtb_ctl_s'(CTL_RESET))
    else $error("control not at reset value after release");
  a_period_wrap: assert property (s_plain_step ##0 (s.ctl.count_mode == CNT_UP && prd_ev)
    |=> s.count == 16'h0)
    else $error("up count did not wrap after period");
  a_up_step: assert property (s_plain_step ##0 (s.ctl.count_mode == CNT_UP && !prd_ev)
    |=> s.count == $past(s.count) + 16'h1)
    else $error("up count did not advance by one");
  a_master_ignore: assert property (run && s.sync_pend && !s.ctl.phase_load_enable && !wr_count
    && s.ctl.count_mode == CNT_UP && !prd_ev |=> s.count == $past(s.count) + 16'h1)
    else $error("sync moved a counter with phase load off");
  a_phase_load: assert property (s_sync_taken |=> s.count == $past(s.phase))
    else $error("sync did not load the phase offset");
  a_phase_dir: assert property (s_sync_taken ##0 (s.ctl.count_mode == CNT_UPDOWN)
    |=> s.dir == $past(s.ctl.phase_direction))
    else $error("direction after sync is wrong");
  a_zero_set: assert property (run && zero_ev && !prd_ev && !cmp_ev
    && s.act.zero_event_action == ACT_SET |=> s.raw_a)
    else $error("output a not set at zero");
  a_cmp_clear: assert property (run && cmp_ev && up_now
    && s.act.compare_a_up_action == ACT_CLEAR |=> !s.raw_a)
    else $error("output a not cleared at compare up");
  a_tick_div2: assert property (s.tick && div == 12'h2 && !wr_ctl |=> !s.tick ##1 s.tick)
    else $error("time base tick not every second clock");
  a_cmp_load: assert property (run && zero_ev && !s.cmp_ctl.compare_a_shadow_select
    && s.cmp_ctl.compare_a_load_event == LOAD_ZERO |=> s.cmp_a == $past(s.cmp_a_sh))
    else $error("shadow compare not loaded at zero");
  a_sync_pass: assert property (sync_pulse && s.ctl.sync_out_source == SYNC_PASS |=> o_sync_out)
    else $error("sync input not passed through");

endmodule

/* dv/pwmtb_bridge_model.sv */
// power stage model: watches the switch pair for shoot-through and dead time
`timescale 1ns/10ps
module pwmtb_bridge_model (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_a,
  input  wire logic i_b,
  output int        o_shoot,
  output int        o_gap_rise,
  output int        o_gap_fall
);
  int   gap;
  logic pa;
  logic pb;

  // both switches on shorts the supply, so any overlap is counted
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_shoot    <= 0;
      o_gap_rise <= 0;
      o_gap_fall <= 0;
      gap        <= 0;
      pa         <= 1'b0;
      pb         <= 1'b0;
    end
    else
    begin
      pa <= i_a;
      pb <= i_b;
      if (i_a === 1'b1 && i_b === 1'b1)
        o_shoot <= o_shoot + 1;
      gap <= (i_a === 1'b0 && i_b === 1'b0) ? gap + 1 : 0;
      if (i_a === 1'b1 && pa === 1'b0)
        o_gap_rise <= gap;
      if (i_b === 1'b1 && pb === 1'b0)
        o_gap_fall <= gap;
    end
  end
endmodule

/* dv/pwmtb_channel_tb.sv */
// self-checking bench for the pwm time base channel
`timescale 1ns/10ps
module pwmtb_channel_tb;
  import pwmtb_pkg::*;
  logic              i_clk;
  logic              i_rst_n;
  logic              i_sync_in;
  pwmtb_bus_s        bus;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rdata_nf;
  logic [DATA_W-1:0] rd_v;
  logic [DATA_W-1:0] rd_nf;
  logic              sync_out;
  logic              out_a;
  logic              out_b;
  logic              seen;
  int                errors;
  int                n_checks;
  int                shoot;
  int                gap_r;
  int                gap_f;
  int                hi;
  int                len;
  int                ph;
  int                dv;
  int                exp_reg [int];

  pwmtb_channel u_dut (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_bus     (bus),
    .i_sync_in (i_sync_in),
    .o_rdata   (rdata),
    .o_sync_out(sync_out),
    .o_out_a   (out_a),
    .o_out_b   (out_b)
  );

  // second channel without the fine phase extension shares the bus, so one period for both
  pwmtb_channel #(.HAS_FINE_PHASE(1'b0)) u_nf (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_bus     (bus),
    .i_sync_in (1'b0),
    .o_rdata   (rdata_nf),
    .o_sync_out(),
    .o_out_a   (),
    .o_out_b   ()
  );

  pwmtb_bridge_model u_stage (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_a       (out_a),
    .i_b       (out_b),
    .o_shoot   (shoot),
    .o_gap_rise(gap_r),
    .o_gap_fall(gap_f)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge i_clk);
    bus.wr    <= 1'b0;
    exp_reg[a] = d;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge i_clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge i_clk);
    bus.rd   <= 1'b0;
    #1;
    rd_v  = rdata;
    rd_nf = rdata_nf;
  endtask

  function automatic logic [DATA_W-1:0] ctl(input int md, pe, src, f, p, dir);
    return DATA_W'(dir << 13 | p << 10 | f << 7 | src << 4 | pe << 2 | md);
  endfunction

  // one full period between sync-out pulses, counting output a high time
  task automatic measure();
    len = 0;
    while (sync_out !== 1'b1)
    begin
      @(posedge i_clk);
      #1;
      if (++len > 20000)
      begin
        errors++;
        close_out();
      end
    end
    len = 0;
    hi  = 0;
    do
    begin
      @(posedge i_clk);
      #1;
      len++;
      if (out_a === 1'b1)
        hi++;
      if (len > 20000)
      begin
        errors++;
        close_out();
      end
    end
    while (sync_out !== 1'b1);
  endtask

  initial
  begin
    errors    = 0;
    n_checks  = 0;
    i_rst_n   = 1'b0;
    i_sync_in = 1'b0;
    bus       = '0;
    void'($urandom(59));
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(OFS_CTL);
    check("ctl reset", rd_v, 16'h0083);
    rd(OFS_PHASE);
    check("phase reset", rd_v, 16'h0000);
    wr(OFS_RED, 16'h0000);
    wr(OFS_FED, 16'h0000);
    wr(OFS_DB_CTL, 16'h000b);
    wr(OFS_CMP_CT, 16'h0000);
    wr(OFS_ACT_A, 16'h0012);
    wr(OFS_PERIOD, 16'h04b0);
    wr(OFS_CMP_A, 16'h0258);
    wr(OFS_CTL, ctl(0, 0, 1, 0, 0, 0));
    measure();
    measure();
    check("period clocks", len, 1201);
    check("high clocks", hi, 600);
    // compare load event never: the new compare must stay in the shadow
    wr(OFS_CMP_CT, 16'h000c);
    wr(OFS_CMP_A, 16'h012c);
    measure();
    check("held compare", hi, 600);
    wr(OFS_CMP_CT, 16'h0000);
    measure();
    measure();
    check("zero load compare", hi, 300);
    wr(OFS_PERIOD, 16'h0014);
    wr(OFS_CMP_A, 16'h000a);
    for (int f = 0; f < 3; f++)
      for (int p = 0; p < 2; p++)
      begin
        dv = (f == 0 ? 1 : 2 * f) * (1 << p);
        wr(OFS_CTL, ctl(0, 0, 1, f, p, 0));
        measure();
        measure();
        check("divided period", len, 21 * dv);
        check("divided high", hi, 10 * dv);
      end
    wr(OFS_CTL, ctl(0, 0, 1, 0, 0, 0));
    wr(OFS_RED, 16'h0003);
    wr(OFS_FED, 16'h0002);
    measure();
    measure();
    check("rise gap", gap_r, 3);
    check("fall gap", gap_f, 2);
    check("delayed high", hi, 7);
    wr(OFS_PERIOD, 16'h03e8);
    for (int k = 0; k < 4; k++)
    begin
      ph = 400 + $urandom % 500;
      wr(OFS_CTL, ctl(k == 2 ? 2 : 0, k != 3, 0, 0, 7, k % 2));
      wr(OFS_COUNT, 16'h0000);
      wr(OFS_PHASE, DATA_W'(ph));
      rd(OFS_PHASE);
      check("phase readback", rd_v, exp_reg[OFS_PHASE]);
      // the pass-through pulse stands one clock, so watch from the first edge
      @(posedge i_clk);
      i_sync_in <= 1'b1;
      seen = 1'b0;
      for (int n = 0; n < 12; n++)
      begin
        @(posedge i_clk);
        if (n == 4)
          i_sync_in <= 1'b0;
        #1;
        seen = seen | (sync_out === 1'b1);
      end
      check("sync pass", seen, 1'b1);
      seen = 1'b0;
      repeat (150)
      begin
        rd(OFS_COUNT);
        seen = seen | (rd_v === DATA_W'(ph));
      end
      check("phase load", seen, k != 3);
      rd(OFS_STATUS);
      check("sync flag", rd_v[STS_SYNC], 1'b1);
      if (k == 2)
        check("updown dir", rd_v[STS_DIR], 1'b0);
    end
    wr(OFS_STATUS, 16'h0002);
    rd(OFS_STATUS);
    check("sync flag clear", rd_v[STS_SYNC], 1'b0);
    // software never writes an unlisted offset, it only reads one back as zero
    rd(8'h0c);
    check("reserved read", rd_v, 16'h0000);
    wr(OFS_FINE, 16'h1234);
    rd(OFS_FINE);
    check("fine phase", rd_v, 16'h1234);
    check("fine absent", rd_nf, 16'h0000);
    check("shoot through", shoot, 0);
    close_out();
  end
endmodule
